/* hw/sbp_pkg.sv */
/*
  Shared constants for the six-bit port with serial pin sharing:
  register indices, byte addresses, field positions and reset values.
  Assumes a 32-bit APB register bus with one register per aligned word.
*/
`default_nettype none

package sbp_pkg;

  // Port width and register data width
  localparam int unsigned PORT_W = 6;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned ADDR_W = 32;

  // Printed offsets are not all word multiples, so they act as indices
  localparam logic [15:0] IDX_PIN_DIRECTION_SELECT = 16'hFEB2;
  localparam logic [15:0] IDX_PIN_LEVEL_READBACK   = 16'hFF52;
  localparam logic [15:0] IDX_OUTPUT_VALUE_LATCH   = 16'hFF62;
  localparam logic [15:0] IDX_OPEN_DRAIN_SELECT    = 16'hFF76;

  // Byte address is four times the index
  localparam logic [ADDR_W-1:0] ADR_PIN_DIRECTION_SELECT = {14'h0000, IDX_PIN_DIRECTION_SELECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_PIN_LEVEL_READBACK   = {14'h0000, IDX_PIN_LEVEL_READBACK, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_OUTPUT_VALUE_LATCH   = {14'h0000, IDX_OUTPUT_VALUE_LATCH, 2'h0};
  localparam logic [ADDR_W-1:0] ADR_OPEN_DRAIN_SELECT    = {14'h0000, IDX_OPEN_DRAIN_SELECT, 2'h0};

  // Reset values of the six live bits
  localparam logic [PORT_W-1:0] RST_DIRECTION  = 6'h00;
  localparam logic [PORT_W-1:0] RST_OUT_VALUE  = 6'h00;
  localparam logic [PORT_W-1:0] RST_OPEN_DRAIN = 6'h00;

  // Value returned when the write-only direction register is read
  localparam logic [31:0] DIR_READ_VALUE = 32'h0000_0000;

  // Pin positions
  localparam int unsigned PIN_TX_CH0  = 0;
  localparam int unsigned PIN_TX_CH1  = 1;
  localparam int unsigned PIN_RX_CH0  = 2;
  localparam int unsigned PIN_RX_CH1  = 3;
  localparam int unsigned PIN_CLK_CH0 = 4;
  localparam int unsigned PIN_CLK_CH1 = 5;

  // Function of a serial clock pin
  typedef enum logic [1:0]
  {
    SBP_CLK_GPIO,
    SBP_CLK_OUT,
    SBP_CLK_IN
  } sbp_clk_fn_t;

endpackage : sbp_pkg

`default_nettype wire

/* hw/sbp_pin_cell.sv */
/*
  One port pin: chooses between general I/O and a peripheral function,
  and applies the open-drain setting to whatever drives the pin.
  Assumes the pad resolves pin_out/pin_oe into the wire level.
*/
`default_nettype none

module sbp_pin_cell
(
  input  wire logic fn_out_i,    // Peripheral owns pin as output
  input  wire logic fn_in_i,     // Peripheral owns pin as input
  input  wire logic fn_data_i,   // Peripheral output value
  input  wire logic dir_i,       // Direction bit, 1 = output
  input  wire logic gpio_data_i, // Output latch bit
  input  wire logic od_i,        // Open-drain bit
  output logic      pin_out_o,   // Level toward the pad
  output logic      pin_oe_o     // Pad driver enable
);

  logic drive;
  logic value;

  // Peripheral output beats input function and direction; an input function alone disables driver
  always_comb
  begin
    drive = 1'b0;
    value = gpio_data_i;
    if (fn_out_i)
    begin
      drive = 1'b1;
      value = fn_data_i;
    end
    else if (!fn_in_i)
    begin
      drive = dir_i;
    end
  end

  // Open drain only pulls low; a high is left to the external pull-up
  always_comb
  begin
    pin_out_o = value & ~od_i;
    pin_oe_o  = drive & (~od_i | ~value);
  end

endmodule : sbp_pin_cell

`default_nettype wire

/* hw/sbp_port.sv */
/*
  Six-bit general-purpose port with pins shared by two serial channels
  and two external interrupt inputs, reached over a 32-bit APB slave.
  Assumes pin inputs already synchronous to core_clk_i, and serial
  channel controls supplied as levels by the serial logic outside.
*/
// Chosen here: the APB register port.
`default_nettype none

module sbp_port
  import sbp_pkg::*;
(
  input  wire logic                core_clk_i,                 // 40 MHz clock
  input  wire logic                rst_i,                      // Power-on reset, sync, high
  input  wire logic                hw_standby_i,               // Hardware standby, clears regs
  input  wire logic                manual_reset_i,             // Manual reset, regs kept
  input  wire logic                sw_standby_i,               // Software standby, regs kept
  // APB slave
  input  wire logic                psel_i,                     // Slave select
  input  wire logic                penable_i,                  // Access phase
  input  wire logic                pwrite_i,                   // 1 = write
  input  wire logic [ADDR_W-1:0]   paddr_i,                    // Byte address
  input  wire logic [31:0]         pwdata_i,                   // Write data
  output logic      [31:0]         prdata_o,                   // Read data
  output logic                     pready_o,                   // Always ready
  output logic                     pslverr_o,                  // Unmapped address
  // Serial channel controls
  input  wire logic [1:0]          serial_sync_mode_i,         // Sync mode bit per channel
  input  wire logic [1:0]          serial_clock_enable_low_i,  // Clock enable low per channel
  input  wire logic [1:0]          serial_clock_enable_high_i, // Clock enable high per channel
  input  wire logic [1:0]          receive_enable_bit_i,       // Receive enable per channel
  input  wire logic [1:0]          transmit_enable_bit_i,      // Transmit enable per channel
  input  wire logic                serial_out_ch0_i,           // Channel 0 transmit data
  input  wire logic                serial_out_ch1_i,           // Channel 1 transmit data
  input  wire logic                serial_clock_ch0_i,         // Channel 0 clock to drive
  input  wire logic                serial_clock_ch1_i,         // Channel 1 clock to drive
  output logic                     serial_in_ch0_o,            // Channel 0 receive data
  output logic                     serial_in_ch1_o,            // Channel 1 receive data
  output logic                     serial_clock_in_ch0_o,      // Channel 0 clock from pin
  output logic                     serial_clock_in_ch1_o,      // Channel 1 clock from pin
  output logic                     ext_interrupt_line4_o,      // Pin 4 level
  output logic                     ext_interrupt_line5_o,      // Pin 5 level
  // Pins
  input  wire logic [PORT_W-1:0]   pin_in_i,                   // Pin levels
  output logic      [PORT_W-1:0]   pin_out_o,                  // Pin output levels
  output logic      [PORT_W-1:0]   pin_oe_o                    // Pin driver enables
);

  // Clock pin selection shared by pins 5 and 4
  function automatic sbp_clk_fn_t clk_pin_fn(input logic cke_high,
                                             input logic sync_mode,
                                             input logic cke_low);
    if (cke_high)
      return SBP_CLK_IN;
    else if (sync_mode || cke_low)
      return SBP_CLK_OUT;
    else
      return SBP_CLK_GPIO;
  endfunction : clk_pin_fn

  logic [PORT_W-1:0] direction_ff;
  logic [PORT_W-1:0] out_value_ff;
  logic [PORT_W-1:0] open_drain_ff;
  logic [PORT_W-1:0] nxt_direction;
  logic [PORT_W-1:0] nxt_out_value;
  logic [PORT_W-1:0] nxt_open_drain;

  logic              wr_en;
  logic              hit_dir;
  logic              hit_rb;
  logic              hit_out;
  logic              hit_od;
  logic              clear_regs;
  logic              serial_off;
  sbp_clk_fn_t       clk_fn_ch0;
  sbp_clk_fn_t       clk_fn_ch1;
  logic [PORT_W-1:0] fn_out;
  logic [PORT_W-1:0] fn_in;
  logic [PORT_W-1:0] fn_data;
  logic [PORT_W-1:0] readback;

  // Address decode
  assign hit_dir = (paddr_i == ADR_PIN_DIRECTION_SELECT);
  assign hit_rb  = (paddr_i == ADR_PIN_LEVEL_READBACK);
  assign hit_out = (paddr_i == ADR_OUTPUT_VALUE_LATCH);
  assign hit_od  = (paddr_i == ADR_OPEN_DRAIN_SELECT);

  // Zero-wait slave; a write lands on the access cycle
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i & penable_i & pwrite_i & ~hw_standby_i;
  assign pslverr_o = psel_i & penable_i & ~(hit_dir | hit_rb | hit_out | hit_od);

  // Only power-on reset and hardware standby clear; manual reset does not
  assign clear_regs = rst_i | hw_standby_i;

  // Serial pin functions are switched off during any reset or standby
  assign serial_off = rst_i | hw_standby_i | manual_reset_i | sw_standby_i;

  // Next values: only bits 5 to 0 are stored, upper write bits dropped
  always_comb
  begin
    nxt_direction  = direction_ff;
    nxt_out_value  = out_value_ff;
    nxt_open_drain = open_drain_ff;
    if (wr_en && hit_dir)
      nxt_direction = pwdata_i[PORT_W-1:0];
    if (wr_en && hit_out)
      nxt_out_value = pwdata_i[PORT_W-1:0];
    if (wr_en && hit_od)
      nxt_open_drain = pwdata_i[PORT_W-1:0];
  end

  // Direction register
  always_ff @(posedge core_clk_i)
  begin
    if (clear_regs)
      direction_ff <= RST_DIRECTION;
    else
      direction_ff <= nxt_direction;
  end

  // Output value latch
  always_ff @(posedge core_clk_i)
  begin
    if (clear_regs)
      out_value_ff <= RST_OUT_VALUE;
    else
      out_value_ff <= nxt_out_value;
  end

  // Open-drain select
  always_ff @(posedge core_clk_i)
  begin
    if (clear_regs)
      open_drain_ff <= RST_OPEN_DRAIN;
    else
      open_drain_ff <= nxt_open_drain;
  end

  // Readback mixes latch and pin per direction bit
  assign readback = (direction_ff & out_value_ff) | (~direction_ff & pin_in_i);

  // Read mux; direction reads return a fixed filler, reserved bits zero
  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (hit_dir)
      prdata_o = DIR_READ_VALUE;
    else if (hit_rb)
      prdata_o = {26'h000_0000, readback};
    else if (hit_out)
      prdata_o = {26'h000_0000, out_value_ff};
    else if (hit_od)
      prdata_o = {26'h000_0000, open_drain_ff};
  end

  // Clock pin decode; no operating-mode input exists by design
  assign clk_fn_ch0 = clk_pin_fn(serial_clock_enable_high_i[0],
                                 serial_sync_mode_i[0],
                                 serial_clock_enable_low_i[0]);
  assign clk_fn_ch1 = clk_pin_fn(serial_clock_enable_high_i[1],
                                 serial_sync_mode_i[1],
                                 serial_clock_enable_low_i[1]);

  // Function ownership per pin; all ownership drops while serial is off
  always_comb
  begin
    fn_out  = 6'h00;
    fn_in   = 6'h00;
    fn_data = 6'h00;
    if (!serial_off)
    begin
      fn_out[PIN_TX_CH0]   = transmit_enable_bit_i[0];
      fn_out[PIN_TX_CH1]   = transmit_enable_bit_i[1];
      fn_in[PIN_RX_CH0]    = receive_enable_bit_i[0];
      fn_in[PIN_RX_CH1]    = receive_enable_bit_i[1];
      fn_out[PIN_CLK_CH0]  = (clk_fn_ch0 == SBP_CLK_OUT);
      fn_in[PIN_CLK_CH0]   = (clk_fn_ch0 == SBP_CLK_IN);
      fn_out[PIN_CLK_CH1]  = (clk_fn_ch1 == SBP_CLK_OUT);
      fn_in[PIN_CLK_CH1]   = (clk_fn_ch1 == SBP_CLK_IN);
    end
    fn_data[PIN_TX_CH0]  = serial_out_ch0_i;
    fn_data[PIN_TX_CH1]  = serial_out_ch1_i;
    fn_data[PIN_CLK_CH0] = serial_clock_ch0_i;
    fn_data[PIN_CLK_CH1] = serial_clock_ch1_i;
  end

  // One cell per pin; open drain covers both general and serial outputs
  for (genvar g = 0; g < PORT_W; g++)
  begin : g_pin
    sbp_pin_cell u_cell
    (
      .fn_out_i    (fn_out[g]),
      .fn_in_i     (fn_in[g]),
      .fn_data_i   (fn_data[g]),
      .dir_i       (direction_ff[g]),
      .gpio_data_i (out_value_ff[g]),
      .od_i        (open_drain_ff[g]),
      .pin_out_o   (pin_out_o[g]),
      .pin_oe_o    (pin_oe_o[g])
    );
  end

  // Inputs toward the serial channels always see the pin level
  assign serial_in_ch0_o       = pin_in_i[PIN_RX_CH0];
  assign serial_in_ch1_o       = pin_in_i[PIN_RX_CH1];
  assign serial_clock_in_ch0_o = pin_in_i[PIN_CLK_CH0];
  assign serial_clock_in_ch1_o = pin_in_i[PIN_CLK_CH1];

  // Interrupt taps ignore the selected function; a shared pin is user's risk
  assign ext_interrupt_line4_o = pin_in_i[PIN_CLK_CH0];
  assign ext_interrupt_line5_o = pin_in_i[PIN_CLK_CH1];

endmodule : sbp_port

`default_nettype wire

/* bench/sbp_port_sva.sv */
/*
  Checker for the six-bit port: pin drive, serial sharing, bus reads.
  Assumes it is bound to every sbp_port and sees only its ports.
*/
`default_nettype none

module sbp_port_sva
  import sbp_pkg::*;
(
  input wire logic              core_clk_i,                 // Clock
  input wire logic              rst_i,                      // Power-on reset
  input wire logic              hw_standby_i,               // Clears registers
  input wire logic              manual_reset_i,             // Keeps registers
  input wire logic              sw_standby_i,               // Keeps registers
  input wire logic              psel_i,                     // Select
  input wire logic              penable_i,                  // Access phase
  input wire logic              pwrite_i,                   // Direction
  input wire logic [ADDR_W-1:0] paddr_i,                    // Byte address
  input wire logic [31:0]       prdata_o,                   // Read data
  input wire logic [1:0]        serial_sync_mode_i,         // Sync mode
  input wire logic [1:0]        serial_clock_enable_low_i,  // Clock out enable
  input wire logic [1:0]        serial_clock_enable_high_i, // Clock in enable
  input wire logic [1:0]        receive_enable_bit_i,       // Receive on
  input wire logic [1:0]        transmit_enable_bit_i,      // Transmit on
  input wire logic              serial_out_ch0_i,           // Tx data
  input wire logic              serial_clock_ch0_i,         // Clock to drive
  input wire logic              ext_interrupt_line4_o,      // Pin 4 level
  input wire logic              ext_interrupt_line5_o,      // Pin 5 level
  input wire logic [PORT_W-1:0] pin_in_i,                   // Pin levels
  input wire logic [PORT_W-1:0] pin_out_o,                  // Drive levels
  input wire logic [PORT_W-1:0] pin_oe_o                    // Drive enables
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Serial functions only count outside reset and standby
  logic act;
  assign act = !(hw_standby_i | manual_reset_i | sw_standby_i);

  AST_TX_DATA: assert property (act && transmit_enable_bit_i[0] && pin_oe_o[0]
    |-> pin_out_o[0] == serial_out_ch0_i) else $error("tx pin level wrong");
  AST_TX_LOW: assert property (act && transmit_enable_bit_i[0] && !serial_out_ch0_i
    |-> pin_oe_o[0]) else $error("tx low not driven");
  AST_RX_OFF: assert property (act && receive_enable_bit_i[1]
    |-> !pin_oe_o[3]) else $error("rx pin driven");
  AST_CLK_IN: assert property (act && serial_clock_enable_high_i[1]
    |-> !pin_oe_o[5]) else $error("clock input pin driven");
  AST_CLK_OUT: assert property (act && !serial_clock_enable_high_i[0]
    && (serial_sync_mode_i[0] || serial_clock_enable_low_i[0]) && !serial_clock_ch0_i
    |-> pin_oe_o[4] && !pin_out_o[4]) else $error("clock out low wrong");
  AST_IRQ: assert property ({ext_interrupt_line5_o, ext_interrupt_line4_o}
    == pin_in_i[5:4]) else $error("interrupt lines differ from pins");
  AST_STANDBY_CLR: assert property (hw_standby_i [*2]
    |-> pin_oe_o == 6'h00) else $error("pins driven in standby");
  AST_DIR_READ: assert property (psel_i && penable_i && !pwrite_i
    && paddr_i == ADR_PIN_DIRECTION_SELECT |-> prdata_o == DIR_READ_VALUE)
    else $error("direction read value wrong");
  AST_HIGH_ZERO: assert property (psel_i && penable_i && !pwrite_i
    |-> prdata_o[31:6] == 26'h0) else $error("reserved read bits set");

  // Main scenarios reached
  COV_TX: cover property (act && transmit_enable_bit_i[0]);
  COV_STBY: cover property (hw_standby_i [*2]);
  COV_WR: cover property (psel_i && penable_i && pwrite_i);
endmodule : sbp_port_sva

bind sbp_port sbp_port_sva i_sva (.core_clk_i, .rst_i, .hw_standby_i, .manual_reset_i,
  .sw_standby_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .serial_sync_mode_i,
  .serial_clock_enable_low_i, .serial_clock_enable_high_i, .receive_enable_bit_i,
  .transmit_enable_bit_i, .serial_out_ch0_i, .serial_clock_ch0_i, .ext_interrupt_line4_o,
  .ext_interrupt_line5_o, .pin_in_i, .pin_out_o, .pin_oe_o);

`default_nettype wire

/* bench/sbp_pin_board.sv */
/*
  Board around the port pins: pull-ups and an external driver.
  Assumes the port's enable wins over the board in contention.
*/
`default_nettype none

module sbp_pin_board
  import sbp_pkg::*;
(
  input  wire logic [PORT_W-1:0] pin_out_i, // Port drive levels
  input  wire logic [PORT_W-1:0] pin_oe_i,  // Port drive enables
  input  wire logic [PORT_W-1:0] ext_val_i, // Board forced level
  input  wire logic [PORT_W-1:0] ext_en_i,  // Board drive enables
  output logic      [PORT_W-1:0] pin_lvl_o  // Resolved wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins when nobody drives, so open-drain ones read high
  always_comb
    for (int i = 0; i < PORT_W; i++)
      pin_lvl_o[i] = pin_oe_i[i] ? pin_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
endmodule : sbp_pin_board

`default_nettype wire

/* bench/sbp_tb.sv */
/*
  Self-checking bench for the six-bit port over APB.
  Assumes zero-wait APB slave and the pin board model around it.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbp_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, hw_standby_i = 1'b0, manual_reset_i = 1'b0;
  logic sw_standby_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o;
  logic pslverr_o, rerr, serial_out_ch0_i = 1'b0, serial_out_ch1_i = 1'b0;
  logic serial_clock_ch0_i = 1'b0, serial_clock_ch1_i = 1'b0, serial_in_ch0_o;
  logic serial_in_ch1_o, serial_clock_in_ch0_o, serial_clock_in_ch1_o;
  logic ext_interrupt_line4_o, ext_interrupt_line5_o;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
  logic [1:0] serial_sync_mode_i = 2'h0, serial_clock_enable_low_i = 2'h0;
  logic [1:0] serial_clock_enable_high_i = 2'h0, receive_enable_bit_i = 2'h0;
  logic [1:0] transmit_enable_bit_i = 2'h0;
  logic [PORT_W-1:0] pin_in_i, pin_out_o, pin_oe_o, ext_val = 6'h00, ext_en = 6'h00;
  int err_total = 0, samples_checked = 0, cyc = 0;

  sbp_port i_dut (.core_clk_i, .rst_i, .hw_standby_i, .manual_reset_i, .sw_standby_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .serial_sync_mode_i, .serial_clock_enable_low_i, .serial_clock_enable_high_i,
    .receive_enable_bit_i, .transmit_enable_bit_i, .serial_out_ch0_i, .serial_out_ch1_i,
    .serial_clock_ch0_i, .serial_clock_ch1_i, .serial_in_ch0_o, .serial_in_ch1_o,
    .serial_clock_in_ch0_o, .serial_clock_in_ch1_o, .ext_interrupt_line4_o,
    .ext_interrupt_line5_o, .pin_in_i, .pin_out_o, .pin_oe_o);
  sbp_pin_board i_board (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_val_i(ext_val),
    .ext_en_i(ext_en), .pin_lvl_o(pin_in_i));

  // 40 MHz clock
  initial
    forever #12.5 core_clk_i = ~core_clk_i;

  // Hang guard; the whole run needs under a hundred cycles
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      print_verdict;
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      err_total++;
    end
  endtask : chk

  // One APB transfer; ends one idle edge later so signals never double-assign
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb

  task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
    chk("pready", 32'(pready_o), 32'h1);
  endtask : rdchk

  task automatic t_reset;
    rdchk("latch", ADR_OUTPUT_VALUE_LATCH, 32'h0);
    rdchk("odr", ADR_OPEN_DRAIN_SELECT, 32'h0);
    rdchk("dir", ADR_PIN_DIRECTION_SELECT, DIR_READ_VALUE);
    chk("oe", 32'(pin_oe_o), 32'h0);
    rdchk("rb", ADR_PIN_LEVEL_READBACK, 32'h3F);
    rdchk("unmapped", 32'h10, 32'h0);
    chk("slverr", 32'(rerr), 32'h1);
    $display("t_reset done");
  endtask : t_reset

  // Bits 7:6 written as ones must not stick
  task automatic t_gpio;
    apb(1'b1, ADR_PIN_DIRECTION_SELECT, 32'hFF);
    apb(1'b1, ADR_OUTPUT_VALUE_LATCH, 32'hEA);
    chk("oe", 32'(pin_oe_o), 32'h3F);
    chk("out", 32'(pin_out_o), 32'h2A);
    rdchk("latch", ADR_OUTPUT_VALUE_LATCH, 32'h2A);
    apb(1'b1, ADR_PIN_LEVEL_READBACK, 32'h15);
    rdchk("rb_out", ADR_PIN_LEVEL_READBACK, 32'h2A);
    apb(1'b1, ADR_PIN_DIRECTION_SELECT, 32'h30);
    ext_en <= 6'h0F;
    ext_val <= 6'h05;
    rdchk("rb_mix", ADR_PIN_LEVEL_READBACK, 32'h25);
    chk("irq", 32'({ext_interrupt_line5_o, ext_interrupt_line4_o}), 32'h2);
    $display("t_gpio done");
  endtask : t_gpio

  // Ones float to the pull-up, zeros stay driven low
  task automatic t_od;
    apb(1'b1, ADR_PIN_DIRECTION_SELECT, 32'h3F);
    apb(1'b1, ADR_OPEN_DRAIN_SELECT, 32'hFF);
    rdchk("odr", ADR_OPEN_DRAIN_SELECT, 32'h3F);
    chk("od_oe", 32'(pin_oe_o), 32'h15);
    chk("od_out", 32'(pin_out_o & pin_oe_o), 32'h0);
    $display("t_od done");
  endtask : t_od

  task automatic t_modes;
    manual_reset_i <= 1'b1;
    transmit_enable_bit_i <= 2'h3;
    repeat (2) @(posedge core_clk_i);
    chk("mr_oe", 32'(pin_oe_o), 32'h15);
    manual_reset_i <= 1'b0;
    sw_standby_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk("ss_oe", 32'(pin_oe_o), 32'h15);
    sw_standby_i <= 1'b0;
    transmit_enable_bit_i <= 2'h0;
    rdchk("keep", ADR_OUTPUT_VALUE_LATCH, 32'h2A);
    rdchk("keep_od", ADR_OPEN_DRAIN_SELECT, 32'h3F);
    hw_standby_i <= 1'b1;
    apb(1'b1, ADR_OUTPUT_VALUE_LATCH, 32'h3F);
    chk("hs_oe", 32'(pin_oe_o), 32'h0);
    hw_standby_i <= 1'b0;
    rdchk("hs_latch", ADR_OUTPUT_VALUE_LATCH, 32'h0);
    rdchk("hs_od", ADR_OPEN_DRAIN_SELECT, 32'h0);
    chk("hs_dir", 32'(pin_oe_o), 32'h0);
    $display("t_modes done");
  endtask : t_modes

  // Serial functions win over direction bits set to output
  task automatic t_serial;
    logic [2:0] cm;
    logic [1:0] e;
    apb(1'b1, ADR_PIN_DIRECTION_SELECT, 32'h3F);
    transmit_enable_bit_i <= 2'h3;
    receive_enable_bit_i <= 2'h3;
    serial_out_ch0_i <= 1'b1;
    serial_out_ch1_i <= 1'b1;
    serial_clock_ch0_i <= 1'b1;
    serial_clock_ch1_i <= 1'b1;
    @(posedge core_clk_i);
    chk("ser_oe", 32'(pin_oe_o[3:0]), 32'h3);
    chk("ser_out", 32'(pin_out_o[1:0]), 32'h3);
    chk("ser_in", 32'({serial_in_ch1_o, serial_in_ch0_o}), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      cm = (k == 3) ? 3'h4 : 3'(k);
      e = (cm == 3'h0) ? 2'h2 : ((cm == 3'h4) ? 2'h0 : 2'h3);
      serial_clock_enable_high_i <= {2{cm[2]}};
      serial_sync_mode_i <= {2{cm[1]}};
      serial_clock_enable_low_i <= {2{cm[0]}};
      @(posedge core_clk_i);
      chk("clk_pin", 32'({pin_oe_o[5], pin_out_o[5] & pin_oe_o[5], pin_oe_o[4],
        pin_out_o[4] & pin_oe_o[4]}), 32'({e, e}));
    end
    chk("clk_in", 32'({serial_clock_in_ch1_o, serial_clock_in_ch0_o}), 32'h3);
    $display("t_serial done");
  endtask : t_serial

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Reset for ten cycles, then the scenarios in turn
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset;
    t_gpio;
    t_od;
    t_modes;
    t_serial;
    print_verdict;
  end
endmodule : tb

`default_nettype wire
